// >>> rtl/esc_pkg.sv
// Shared constants and types for the E1 switch configuration decoder.
package esc_pkg;

    // Switch positions inside the option bank; position 1 is bit 0.
    localparam int SW_LINE_CODE = 0;
    localparam int SW_BUILD_OUT = 2;
    localparam int SW_CLK_HIGH = 5;
    localparam int SW_CLK_LOW = 6;
    localparam int SW_LOOP_GATE = 7;

    // Whole-bank patterns; a set bit means the switch is in the on position.
    localparam logic [7:0] BANK_ALL_ON = 8'hFF;
    localparam logic [7:0] BANK_ALL_OFF = 8'h00;
    localparam logic [7:0] SW_BANK_RESET = 8'h00;

    // Transmit timing sources.
    typedef enum logic [1:0] {
        CLK_NETWORK = 2'b00,
        CLK_INTERNAL = 2'b01,
        CLK_EXTERNAL = 2'b10
    } esc_clk_mode_t;

    // Control modes chosen by the management bank.
    typedef enum logic [1:0] {
        CTRL_LOCAL = 2'b00,
        CTRL_HW_RESET = 2'b01,
        CTRL_REMOTE = 2'b10
    } esc_ctrl_mode_t;

    // Switch capture sequence.
    typedef enum logic {
        CAP_SAMPLE = 1'b0,
        CAP_HOLD = 1'b1
    } esc_cap_state_t;

    // Register byte offsets on the Wishbone bus.
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_ADDRESS = 8'h04;
    localparam logic [7:0] REG_RATE = 8'h08;
    localparam logic [7:0] REG_MGMT_CFG = 8'h0C;

    // Status register fields.
    localparam int ST_LINE_CODE = 0;
    localparam int ST_BUILD_OUT = 1;
    localparam int ST_CLK_LSB = 2;
    localparam int ST_LOOP_EN = 4;
    localparam int ST_LOOP_ACT = 5;
    localparam int ST_REMOTE = 6;
    localparam int ST_SPECIAL = 7;
    localparam int ST_VALID = 8;
    localparam int ST_CTRL_LSB = 9;
    localparam int ST_FITTED = 11;

    // Management configuration fields, used only under remote control.
    localparam int MC_LINE_CODE = 0;
    localparam int MC_BUILD_OUT = 1;
    localparam int MC_CLK_LSB = 2;
    localparam int MC_LOOP_DIS = 4;
    localparam int MC_W = 5;
    localparam logic [4:0] MGMT_CFG_RESET = 5'h00;

    // Line rate report: unstructured 2.048 Mbps.
    localparam logic [15:0] LINE_RATE_KBPS = 16'h0800;
    localparam int RATE_UNSTRUCT_BIT = 16;

endpackage

// >>> rtl/esc_cfg_if.sv
// Carrier between the capture logic and the switch decoder.
`timescale 1ns/1ps
interface esc_cfg_if;
    import esc_pkg::*;

    logic [7:0] opt_bank;
    logic [7:0] mgmt_bank;
    logic line_code_ami;
    logic build_out_75;
    esc_clk_mode_t clk_mode;
    logic loop_gate_en;
    esc_ctrl_mode_t ctrl_mode;
    logic [7:0] card_addr;
    logic all_on;

    modport decoder (
        input opt_bank, mgmt_bank,
        output line_code_ami, build_out_75, clk_mode, loop_gate_en, ctrl_mode,
        output card_addr, all_on
    );

    modport core (
        output opt_bank, mgmt_bank,
        input line_code_ami, build_out_75, clk_mode, loop_gate_en, ctrl_mode,
        input card_addr, all_on
    );
endinterface

// >>> rtl/esc_switch_decode.sv
// Combinational decode of the captured option and management banks.
`timescale 1ns/1ps
module esc_switch_decode
    import esc_pkg::*;
(
    // Captured switches in, decoded settings out.
    esc_cfg_if.decoder cfg
);

    // Option bank decode; reserved positions are looked at only by the all-on check.
    always_comb begin
        cfg.line_code_ami = cfg.opt_bank[SW_LINE_CODE];
        cfg.build_out_75 = cfg.opt_bank[SW_BUILD_OUT];
        cfg.loop_gate_en = !cfg.opt_bank[SW_LOOP_GATE];
        case ({cfg.opt_bank[SW_CLK_HIGH], cfg.opt_bank[SW_CLK_LOW]})
            2'b10: begin
                cfg.clk_mode = CLK_INTERNAL;
            end
            2'b01: begin
                cfg.clk_mode = CLK_EXTERNAL;
            end
            default: begin
                cfg.clk_mode = CLK_NETWORK;
            end
        endcase
    end

    // Management bank selects the control mode.
    always_comb begin
        if (cfg.mgmt_bank == BANK_ALL_OFF) begin
            cfg.ctrl_mode = CTRL_LOCAL;
        end else if (cfg.mgmt_bank == BANK_ALL_ON) begin
            cfg.ctrl_mode = CTRL_HW_RESET;
        end else begin
            cfg.ctrl_mode = CTRL_REMOTE;
        end
    end

    // An on switch reads as zero; position 1 lands in the LSB.
    for (genvar i = 0; i < 8; i++) begin : g_addr
        assign cfg.card_addr[i] = !cfg.mgmt_bank[i];
    end

    // Every switch of both banks on requests the forced local mode.
    assign cfg.all_on = (&cfg.opt_bank) && (&cfg.mgmt_bank);

endmodule

// >>> rtl/esc_config_top.sv
// E1 switch configuration decoder with a Wishbone status and management port.
`timescale 1ns/1ps
module esc_config_top
    import esc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Switch banks and module fit strap; a set bit means on.
    input wire logic [7:0] option_switch_bank,
    input wire logic [7:0] management_address_bank,
    input wire logic ten_base_t_fitted,
    // Attached terminal.
    input wire logic test_mode_request,
    // Line interface settings.
    output logic line_code_ami,
    output logic line_build_out_75,
    output logic unstructured_line_up,
    output logic loopback_active,
    // Transmit timing selection, one-hot.
    output logic tx_timing_recovered,
    output logic tx_timing_internal,
    output logic tx_timing_terminal,
    // Management status.
    output logic remote_management_control,
    output logic [7:0] card_address,
    output logic special_mode,
    output logic config_valid
);

    // Captured switches and capture sequencing.
    logic [7:0] opt_cap_reg;
    logic [7:0] mgmt_cap_reg;
    logic fitted_cap_reg;
    esc_cap_state_t cap_state_reg;
    esc_cap_state_t cap_state_next;
    logic valid;

    // Decoder carrier.
    esc_cfg_if cfg();

    // Selected settings before registering.
    logic remote_eff;
    logic sel_ami;
    logic sel_75;
    logic sel_loop_en;
    esc_clk_mode_t sel_clk;
    esc_clk_mode_t eff_clk;

    // Output registers.
    logic line_code_ami_reg;
    logic build_out_75_reg;
    logic line_up_reg;
    logic loopback_reg;
    logic timing_recovered_reg;
    logic timing_internal_reg;
    logic timing_terminal_reg;
    logic remote_reg;
    logic [7:0] card_addr_reg;
    logic special_reg;

    // Bus side.
    logic wb_req;
    logic wb_ack_reg;
    logic [31:0] wb_dat_reg;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [MC_W-1:0] mgmt_cfg_reg;
    logic [1:0] mc_clk_field;

    // The decoder sees only the captured copies, never the live switches.
    assign cfg.opt_bank = opt_cap_reg;
    assign cfg.mgmt_bank = mgmt_cap_reg;

    esc_switch_decode u_decode (
        .cfg(cfg)
    );

    // Capture sequence: sample once on the first edge after reset release.
    always_comb begin
        case (cap_state_reg)
            CAP_SAMPLE: begin
                cap_state_next = CAP_HOLD;
            end
            CAP_HOLD: begin
                cap_state_next = CAP_HOLD;
            end
            default: begin
                cap_state_next = CAP_SAMPLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cap_state_reg <= CAP_SAMPLE;
        end else begin
            cap_state_reg <= cap_state_next;
        end
    end

    // Switch capture. Taking them after release keeps reset to constants only,
    // and holding them means a slipped switch on a live card changes nothing.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            opt_cap_reg <= SW_BANK_RESET;
            mgmt_cap_reg <= SW_BANK_RESET;
            fitted_cap_reg <= 1'b0;
        end else if (cap_state_reg == CAP_SAMPLE) begin
            opt_cap_reg <= option_switch_bank;
            mgmt_cap_reg <= management_address_bank;
            fitted_cap_reg <= ten_base_t_fitted;
        end
    end

    assign valid = (cap_state_reg == CAP_HOLD);

    // Remote control applies only to a real address; the all-on power-up
    // pattern is excluded explicitly so it always lands on local control.
    assign remote_eff = valid && (cfg.ctrl_mode == CTRL_REMOTE) && !cfg.all_on;

    // The management clock field treats its unused code as network timing.
    assign mc_clk_field = mgmt_cfg_reg[MC_CLK_LSB +: 2];

    // Setting source: local switches, or the management register when remote.
    always_comb begin
        sel_ami = cfg.line_code_ami;
        sel_75 = cfg.build_out_75;
        sel_loop_en = cfg.loop_gate_en;
        sel_clk = cfg.clk_mode;
        if (remote_eff) begin
            sel_ami = mgmt_cfg_reg[MC_LINE_CODE];
            sel_75 = mgmt_cfg_reg[MC_BUILD_OUT];
            sel_loop_en = !mgmt_cfg_reg[MC_LOOP_DIS];
            case (mc_clk_field)
                CLK_INTERNAL: begin
                    sel_clk = CLK_INTERNAL;
                end
                CLK_EXTERNAL: begin
                    sel_clk = CLK_EXTERNAL;
                end
                default: begin
                    sel_clk = CLK_NETWORK;
                end
            endcase
        end
        eff_clk = sel_clk;
        if (sel_clk == CLK_EXTERNAL && fitted_cap_reg) begin
            eff_clk = CLK_INTERNAL;
        end
    end

    // Line settings; reset values are the factory defaults.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            line_code_ami_reg <= 1'b0;
            build_out_75_reg <= 1'b0;
            line_up_reg <= 1'b0;
        end else begin
            line_code_ami_reg <= valid ? sel_ami : 1'b0;
            build_out_75_reg <= valid ? sel_75 : 1'b0;
            line_up_reg <= valid;
        end
    end

    // Transmit timing source, exactly one active at any time.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            timing_recovered_reg <= 1'b1;
            timing_internal_reg <= 1'b0;
            timing_terminal_reg <= 1'b0;
        end else begin
            timing_recovered_reg <= (eff_clk == CLK_NETWORK);
            timing_internal_reg <= (eff_clk == CLK_INTERNAL);
            timing_terminal_reg <= (eff_clk == CLK_EXTERNAL);
        end
    end

    // Loopback follows the live request, gated by the handling enable.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            loopback_reg <= 1'b0;
        end else begin
            loopback_reg <= valid && sel_loop_en && test_mode_request;
        end
    end

    // Control mode, card address and the forced local indication.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            remote_reg <= 1'b0;
            card_addr_reg <= BANK_ALL_OFF;
            special_reg <= 1'b0;
        end else begin
            remote_reg <= remote_eff;
            card_addr_reg <= remote_eff ? cfg.card_addr : BANK_ALL_OFF;
            special_reg <= valid && cfg.all_on;
        end
    end

    // Management configuration register, written over the bus. The forced
    // local mode wipes it so a stale remote setting cannot survive.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mgmt_cfg_reg <= MGMT_CFG_RESET;
        end else if (special_reg) begin
            mgmt_cfg_reg <= MGMT_CFG_RESET;
        end else if (wb_req && !wb_ack_reg && wb_we_i && wb_sel_i[0]
                     && (wb_adr_i == REG_MGMT_CFG)) begin
            mgmt_cfg_reg <= wb_dat_i[MC_W-1:0];
        end
    end

    // Status word built from the block's own state.
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_LINE_CODE] = line_code_ami_reg;
        status_word[ST_BUILD_OUT] = build_out_75_reg;
        status_word[ST_CLK_LSB +: 2] = eff_clk;
        status_word[ST_LOOP_EN] = sel_loop_en;
        status_word[ST_LOOP_ACT] = loopback_reg;
        status_word[ST_REMOTE] = remote_reg;
        status_word[ST_SPECIAL] = special_reg;
        status_word[ST_VALID] = valid;
        status_word[ST_CTRL_LSB +: 2] = cfg.ctrl_mode;
        status_word[ST_FITTED] = fitted_cap_reg;
    end

    // Read decode; unmapped offsets read as zero and still acknowledge.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            REG_STATUS: begin
                rd_mux = status_word;
            end
            REG_ADDRESS: begin
                rd_mux[7:0] = card_addr_reg;
            end
            REG_RATE: begin
                rd_mux[15:0] = LINE_RATE_KBPS;
                rd_mux[RATE_UNSTRUCT_BIT] = 1'b1;
            end
            REG_MGMT_CFG: begin
                rd_mux[MC_W-1:0] = mgmt_cfg_reg;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Wishbone handshake: ack one cycle after the request, dropped after one.
    assign wb_req = wb_cyc_i && wb_stb_i;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wb_ack_reg <= 1'b0;
            wb_dat_reg <= 32'h0000_0000;
        end else begin
            wb_ack_reg <= wb_req && !wb_ack_reg;
            if (wb_req && !wb_ack_reg && !wb_we_i) begin
                wb_dat_reg <= rd_mux;
            end else begin
                wb_dat_reg <= 32'h0000_0000;
            end
        end
    end

    // Port drivers.
    assign wb_ack_o = wb_ack_reg;
    assign wb_dat_o = wb_dat_reg;
    assign line_code_ami = line_code_ami_reg;
    assign line_build_out_75 = build_out_75_reg;
    assign unstructured_line_up = line_up_reg;
    assign loopback_active = loopback_reg;
    assign tx_timing_recovered = timing_recovered_reg;
    assign tx_timing_internal = timing_internal_reg;
    assign tx_timing_terminal = timing_terminal_reg;
    assign remote_management_control = remote_reg;
    assign card_address = card_addr_reg;
    assign special_mode = special_reg;
    assign config_valid = valid;

    // Checks below watch the decoded outputs against the captured switches.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Two valid cycles in a row: the output registers have caught up.
    sequence s_settled;
        config_valid ##1 config_valid;
    endsequence

    sequence s_local_settled;
        s_settled ##0 !remote_eff;
    endsequence

    a_release_capture: assert property ($rose(resetn) |=> config_valid
        && opt_cap_reg == $past(option_switch_bank))
        else $error("switches not captured after reset release");

    a_capture_hold: assert property (config_valid |=> $stable(opt_cap_reg)
        && $stable(mgmt_cap_reg))
        else $error("captured switches changed after capture");

    a_line_up: assert property (config_valid |=> unstructured_line_up)
        else $error("line not up after configuration");

    a_line_code_map: assert property (s_local_settled |->
        line_code_ami == opt_cap_reg[SW_LINE_CODE])
        else $error("line code does not follow its switch");

    a_build_out_map: assert property (s_local_settled |->
        line_build_out_75 == opt_cap_reg[SW_BUILD_OUT])
        else $error("build-out does not follow its switch");

    a_clk_mode_map: assert property (s_local_settled ##0 !fitted_cap_reg |->
        tx_timing_internal == (opt_cap_reg[SW_CLK_HIGH] && !opt_cap_reg[SW_CLK_LOW])
        && tx_timing_terminal == (!opt_cap_reg[SW_CLK_HIGH] && opt_cap_reg[SW_CLK_LOW]))
        else $error("clock mode decode wrong");

    a_timing_onehot: assert property ($onehot({tx_timing_recovered,
        tx_timing_internal, tx_timing_terminal}))
        else $error("transmit timing selection not one-hot");

    a_ext_fallback: assert property (s_settled ##0 fitted_cap_reg |->
        !tx_timing_terminal)
        else $error("terminal timing used with module fitted");

    a_loop_gate_off: assert property (config_valid && !remote_eff
        && opt_cap_reg[SW_LOOP_GATE] |=> !loopback_active)
        else $error("loop request honoured while gated");

    a_loop_follow: assert property (config_valid && !remote_eff && test_mode_request
        && !opt_cap_reg[SW_LOOP_GATE] |=> loopback_active)
        else $error("enabled loop request not honoured");

    a_local_modes: assert property (s_settled ##0 (mgmt_cap_reg == BANK_ALL_OFF
        || mgmt_cap_reg == BANK_ALL_ON) |-> !remote_management_control)
        else $error("local pattern gave remote control");

    a_remote_addr: assert property (s_settled ##0 (cfg.ctrl_mode == CTRL_REMOTE) |->
        remote_management_control && card_address == ~mgmt_cap_reg)
        else $error("remote control or card address wrong");

    a_special_force: assert property (s_settled ##0 (&opt_cap_reg) && (&mgmt_cap_reg)
        |-> special_mode && !remote_management_control)
        else $error("all-on power-up did not force local control");

    a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held longer than one cycle");

endmodule

// >>> dv/esc_switch_model.sv
// Model of the two switch banks and the attached terminal's loop request line.
`timescale 1ns/1ps
module esc_switch_model (
    // Clock.
    input wire logic clk,
    // Settings chosen by the bench.
    input wire logic [7:0] opt_set,
    input wire logic [7:0] mgmt_set,
    input wire logic loop_want,
    // Pins seen by the decoder; a set bit means the switch is on.
    output logic [7:0] option_switch_bank,
    output logic [7:0] management_address_bank,
    output logic test_mode_request
);
    // Switches are static levels; the bench sets them in reset and moves them once after capture.
    assign option_switch_bank = opt_set;
    assign management_address_bank = mgmt_set;

    // The terminal moves its loop request just after an edge and holds it as a level.
    always @(posedge clk) begin
        test_mode_request <= loop_want;
    end
endmodule

// >>> dv/esc_config_top_bench.sv
// Self-checking bench for the E1 switch configuration decoder.
`timescale 1ns/1ps
module esc_config_top_bench;
    import esc_pkg::*;

    // One power-up case: switches in, decoded settings expected out.
    typedef struct packed {
        logic [7:0] opt;
        logic [7:0] mgmt;
        logic fit, ami, b75;
        logic [2:0] clk3;
        logic rem;
        logic [7:0] addr;
        logic spc, loop;
    } esc_row_t;

    logic clk = 1'h0, resetn = 1'h0, ten_base_t_fitted = 1'h0, loop_want = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00, opt_set = 8'h00, mgmt_set = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, line_code_ami, line_build_out_75, unstructured_line_up, loopback_active;
    logic tx_timing_recovered, tx_timing_internal, tx_timing_terminal;
    logic remote_management_control, special_mode, config_valid, test_mode_request;
    logic [7:0] option_switch_bank, management_address_bank, card_address;
    int n_errors = 0, num_checks = 0;

    // Ordinary cases; timing column is {recovered, internal, terminal}.
    esc_row_t rows [14] = '{
        '{8'h00, 8'h00, 1'h0, 1'h0, 1'h0, 3'h4, 1'h0, 8'h00, 1'h0, 1'h1},
        '{8'h01, 8'h00, 1'h0, 1'h1, 1'h0, 3'h4, 1'h0, 8'h00, 1'h0, 1'h1},
        '{8'h04, 8'h00, 1'h0, 1'h0, 1'h1, 3'h4, 1'h0, 8'h00, 1'h0, 1'h1},
        '{8'h20, 8'h00, 1'h0, 1'h0, 1'h0, 3'h2, 1'h0, 8'h00, 1'h0, 1'h1},
        '{8'h40, 8'h00, 1'h0, 1'h0, 1'h0, 3'h1, 1'h0, 8'h00, 1'h0, 1'h1},
        '{8'h40, 8'h00, 1'h1, 1'h0, 1'h0, 3'h2, 1'h0, 8'h00, 1'h0, 1'h1},
        '{8'h60, 8'h00, 1'h0, 1'h0, 1'h0, 3'h4, 1'h0, 8'h00, 1'h0, 1'h1},
        '{8'h1A, 8'h00, 1'h0, 1'h0, 1'h0, 3'h4, 1'h0, 8'h00, 1'h0, 1'h1},
        '{8'h80, 8'h00, 1'h0, 1'h0, 1'h0, 3'h4, 1'h0, 8'h00, 1'h0, 1'h0},
        '{8'h01, 8'hFF, 1'h0, 1'h1, 1'h0, 3'h4, 1'h0, 8'h00, 1'h0, 1'h1},
        '{8'h05, 8'hFE, 1'h0, 1'h0, 1'h0, 3'h4, 1'h1, 8'h01, 1'h0, 1'h1},
        '{8'h00, 8'h4A, 1'h0, 1'h0, 1'h0, 3'h4, 1'h1, 8'hB5, 1'h0, 1'h1},
        '{8'hFF, 8'hFF, 1'h0, 1'h1, 1'h1, 3'h4, 1'h0, 8'h00, 1'h1, 1'h0},
        '{8'h00, 8'h00, 1'h0, 1'h0, 1'h0, 3'h4, 1'h0, 8'h00, 1'h0, 1'h1}
    };

    // Free-running 200 MHz clock.
    always #2.5 clk = ~clk;

    esc_switch_model u_esc_switch_model (.clk(clk), .opt_set(opt_set), .mgmt_set(mgmt_set),
        .loop_want(loop_want), .option_switch_bank(option_switch_bank),
        .management_address_bank(management_address_bank),
        .test_mode_request(test_mode_request));

    esc_config_top u_esc_config_top (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .option_switch_bank(option_switch_bank),
        .management_address_bank(management_address_bank),
        .ten_base_t_fitted(ten_base_t_fitted), .test_mode_request(test_mode_request),
        .line_code_ami(line_code_ami), .line_build_out_75(line_build_out_75),
        .unstructured_line_up(unstructured_line_up), .loopback_active(loopback_active),
        .tx_timing_recovered(tx_timing_recovered), .tx_timing_internal(tx_timing_internal),
        .tx_timing_terminal(tx_timing_terminal),
        .remote_management_control(remote_management_control),
        .card_address(card_address), .special_mode(special_mode),
        .config_valid(config_valid));

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Holds reset for six cycles with the switches set, then lets capture settle.
    task automatic power_up(input logic [7:0] o, input logic [7:0] m, input logic f);
        resetn <= 1'h0;
        opt_set <= o;
        mgmt_set <= m;
        ten_base_t_fitted <= f;
        repeat (6) @(posedge clk);
        resetn <= 1'h1;
        repeat (4) @(posedge clk);
    endtask

    // One classic Wishbone cycle; the request is held until ack is sampled high.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'h1);
        chk("wb_latency", n, 32'h2);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask

    // Raises or drops the terminal request and checks the loopback state it gives.
    task automatic loop_chk(input logic want, input logic exp);
        loop_want <= want;
        repeat (4) @(posedge clk);
        chk("loopback_active", {31'h0, loopback_active}, {31'h0, exp});
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // A hang is cut short well beyond the few hundred cycles the tests need.
    initial begin
        #40000;
        n_errors++;
        wrap_up();
    end

    initial begin
        foreach (rows[i]) begin
            power_up(rows[i].opt, rows[i].mgmt, rows[i].fit);
            chk("line_code_ami", line_code_ami, rows[i].ami);
            chk("line_build_out_75", line_build_out_75, rows[i].b75);
            chk("tx_timing", {tx_timing_recovered, tx_timing_internal, tx_timing_terminal},
                rows[i].clk3);
            chk("remote", remote_management_control, rows[i].rem);
            chk("card_address", card_address, rows[i].addr);
            chk("special_mode", special_mode, rows[i].spc);
            chk("line_up", {unstructured_line_up, config_valid}, 32'h3);
            loop_chk(1'h1, rows[i].loop);
            loop_chk(1'h0, 1'h0);
        end
        // Switch moves after capture must not reach the settings.
        power_up(8'h00, 8'h00, 1'h0);
        opt_set <= 8'h05;
        mgmt_set <= 8'hFE;
        repeat (4) @(posedge clk);
        chk("held_settings", {line_code_ami, remote_management_control}, 32'h0);
        // Remote control: status, address, rate, an unmapped and a read-only place.
        power_up(8'h00, 8'hFE, 1'h0);
        wb(1'h0, REG_STATUS, 32'h0, 4'hF);
        chk("status", rd, 32'h550);
        wb(1'h0, REG_ADDRESS, 32'h0, 4'hF);
        chk("address", rd, 32'h1);
        wb(1'h0, REG_RATE, 32'h0, 4'hF);
        chk("rate", rd, 32'h10800);
        wb(1'h1, 8'h10, 32'hFFFF_FFFF, 4'hF);
        wb(1'h0, 8'h10, 32'h0, 4'hF);
        chk("unmapped", rd, 32'h0);
        wb(1'h1, REG_STATUS, 32'hFFFF_FFFF, 4'hF);
        wb(1'h0, REG_STATUS, 32'h0, 4'hF);
        chk("status_ro", rd, 32'h550);
        // Management settings: AMI, 75 ohm, internal timing, then a write without sel.
        wb(1'h1, REG_MGMT_CFG, 32'h7, 4'h1);
        wb(1'h1, REG_MGMT_CFG, 32'h0, 4'h0);
        repeat (2) @(posedge clk);
        chk("remote_cfg", {line_code_ami, line_build_out_75, tx_timing_internal}, 32'h7);
        // Loop handling disabled and network timing selected from the bus.
        wb(1'h1, REG_MGMT_CFG, 32'h1C, 4'h1);
        wb(1'h0, REG_MGMT_CFG, 32'h0, 4'hF);
        chk("mgmt_cfg", rd, 32'h1C);
        chk("remote_net", tx_timing_recovered, 32'h1);
        loop_chk(1'h1, 1'h0);
        loop_chk(1'h0, 1'h0);
        // Terminal timing chosen from the bus.
        wb(1'h1, REG_MGMT_CFG, 32'h8, 4'h1);
        repeat (2) @(posedge clk);
        chk("remote_ext", tx_timing_terminal, 32'h1);
        // Reset puts every output to its idle value before the capture.
        resetn <= 1'h0;
        repeat (2) @(posedge clk);
        chk("reset_out", {line_code_ami, remote_management_control, loopback_active,
            tx_timing_recovered, config_valid, card_address}, 32'h200);
        // Forced local mode keeps the management register cleared.
        power_up(8'hFF, 8'hFF, 1'h0);
        wb(1'h1, REG_MGMT_CFG, 32'h1F, 4'h1);
        wb(1'h0, REG_MGMT_CFG, 32'h0, 4'hF);
        chk("special_cfg", rd, 32'h0);
        wrap_up();
    end
endmodule
